//--- hdl/sar_host_end.sv
`include "sar_link_defines.svh"

module sar_host_end
    import sar_link_pkg::*;
#(
    parameter int RESULT_BITS = `RESULT_BITS,
    parameter int MAX_CHAIN   = 8,
    parameter int WAIT_CYCLES = `CONV_CYCLES + `SYNC_MARGIN_CYCLES,
    parameter int HALF_CYCLES = `SCK_HALF_CYCLES
) (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         reset,
    // link pins
    sar_link_if.host                          link,
    // user request
    input  wire logic                         start,
    input  wire link_mode_e                   mode,
    input  wire logic [$clog2(MAX_CHAIN)-1:0] chain_len_m1,
    // user answer
    output logic [RESULT_BITS-1:0]            result_word,
    output logic                              result_valid,
    output logic [$clog2(MAX_CHAIN)-1:0]      result_index,
    output logic                              busy
);

    localparam int TMR_W = $clog2(WAIT_CYCLES + 1);
    localparam int BIT_W = $clog2(RESULT_BITS + 1);
    localparam int IDX_W = $clog2(MAX_CHAIN);
    localparam logic [TMR_W-1:0] WAIT_LAST  = TMR_W'(WAIT_CYCLES - 1);
    localparam logic [TMR_W-1:0] HALF_LAST  = TMR_W'(HALF_CYCLES - 1);
    localparam logic [TMR_W-1:0] SETUP_LAST = TMR_W'(`SETUP_CYCLES - 1);
    localparam logic [BIT_W-1:0] BIT_LAST   = BIT_W'(RESULT_BITS - 1);

    // serial output synchroniser
    logic line_meta_reg;
    logic line_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            line_meta_reg <= 1'b0;
            line_reg      <= 1'b0;
        end else begin
            line_meta_reg <= link.result_line;
            line_reg      <= line_meta_reg;
        end
    end

    host_state_e            state_reg;
    host_state_e            state_next;
    link_mode_e             mode_reg;
    link_mode_e             mode_next;
    logic [IDX_W-1:0]       len_reg;
    logic [IDX_W-1:0]       len_next;
    logic [TMR_W-1:0]       tmr_reg;
    logic [TMR_W-1:0]       tmr_next;
    logic [BIT_W-1:0]       bit_reg;
    logic [BIT_W-1:0]       bit_next;
    logic [IDX_W-1:0]       idx_reg;
    logic [IDX_W-1:0]       idx_next;
    logic [RESULT_BITS-1:0] word_reg;
    logic [RESULT_BITS-1:0] word_next;
    logic                   go_reg;
    logic                   go_next;
    logic                   sck_reg;
    logic                   sck_next;
    logic                   sel_reg;
    logic                   sel_next;
    logic                   valid_reg;
    logic                   valid_next;
    logic                   busy_reg;
    logic                   busy_next;

    always_comb begin
        state_next = state_reg;
        mode_next  = mode_reg;
        len_next   = len_reg;
        tmr_next   = tmr_reg + 1'b1;
        bit_next   = bit_reg;
        idx_next   = idx_reg;
        word_next  = word_reg;
        go_next    = go_reg;
        sck_next   = sck_reg;
        sel_next   = sel_reg;
        valid_next = 1'b0;
        busy_next  = (state_reg != HOST_IDLE);
        unique case (state_reg)
            HOST_IDLE: begin
                tmr_next = '0;
                if (start) begin
                    state_next = HOST_ARM;
                    mode_next  = mode;
                    len_next   = (mode == MODE_CHAIN) ? chain_len_m1 : '0;
                    busy_next  = 1'b1;
                end
            end
            HOST_ARM: begin
                // select level must settle before the start edge
                sel_next = (mode_reg != MODE_CHAIN); // R14
                sck_next = 1'b0;
                if (tmr_reg == SETUP_LAST) begin
                    state_next = HOST_CONVERT;
                    go_next    = 1'b1;
                    tmr_next   = '0;
                end
            end
            HOST_CONVERT: begin
                // sck stays low and select high (low in chain mode) for the whole wait
                if (tmr_reg == WAIT_LAST) begin // R2 R11 R19
                    state_next = HOST_SELECT;
                    tmr_next   = '0;
                    bit_next   = '0;
                    idx_next   = '0;
                    if (mode_reg == MODE_THREE_WIRE) begin
                        go_next = 1'b0;
                    end else if (mode_reg == MODE_FOUR_WIRE) begin
                        sel_next = 1'b0;
                    end
                end
            end
            HOST_SELECT: begin
                if (tmr_reg == HALF_LAST) begin
                    state_next = HOST_SCK_HIGH;
                    sck_next   = 1'b1;
                    tmr_next   = '0;
                end
            end
            HOST_SCK_HIGH: begin
                if (tmr_reg == HALF_LAST) begin
                    // sample late in the high phase, just before the fall
                    word_next  = {word_reg[RESULT_BITS-2:0], line_reg}; // R7
                    state_next = HOST_SCK_LOW;
                    sck_next   = 1'b0;
                    tmr_next   = '0;
                    if (bit_reg == BIT_LAST) begin
                        valid_next = 1'b1;
                    end
                end
            end
            HOST_SCK_LOW: begin
                if (tmr_reg == HALF_LAST) begin
                    tmr_next = '0;
                    if (bit_reg != BIT_LAST) begin
                        bit_next   = bit_reg + 1'b1;
                        state_next = HOST_SCK_HIGH;
                        sck_next   = 1'b1;
                    end else if (idx_reg != len_reg) begin
                        bit_next   = '0;
                        idx_next   = idx_reg + 1'b1; // R18
                        state_next = HOST_SCK_HIGH;
                        sck_next   = 1'b1;
                    end else begin
                        // start held high until here in four-wire and chain
                        state_next = HOST_DONE; // R9 R15
                        sel_next   = (mode_reg != MODE_CHAIN);
                    end
                end
            end
            HOST_DONE: begin
                go_next    = 1'b0;
                state_next = HOST_IDLE;
            end
            default: begin
                state_next = HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= HOST_IDLE;
            mode_reg  <= MODE_THREE_WIRE;
            len_reg   <= '0;
            tmr_reg   <= '0;
            bit_reg   <= '0;
            idx_reg   <= '0;
            word_reg  <= '0;
            go_reg    <= 1'b0;
            sck_reg   <= 1'b0;
            sel_reg   <= 1'b1;
            valid_reg <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            mode_reg  <= mode_next;
            len_reg   <= len_next;
            tmr_reg   <= tmr_next;
            bit_reg   <= bit_next;
            idx_reg   <= idx_next;
            word_reg  <= word_next;
            go_reg    <= go_next;
            sck_reg   <= sck_next;
            sel_reg   <= sel_next;
            valid_reg <= valid_next;
            busy_reg  <= busy_next;
        end
    end

    assign link.conversion_start      = go_reg;
    assign link.sck                   = sck_reg;
    assign link.select_or_chain_input = sel_reg;
    assign result_word                = word_reg;
    assign result_valid               = valid_reg;
    assign result_index               = idx_reg;
    assign busy                       = busy_reg;

endmodule : sar_host_end

//--- hdl/sar_link_defines.svh
`ifndef SAR_LINK_DEFINES_SVH
`define SAR_LINK_DEFINES_SVH

// result width and clock
`define RESULT_BITS         18
`define CLK_PERIOD_NS       8

// longest conversion time and its cycle count, rounded up
`define CONV_TIME_MAX_NS    1600
`define CONV_CYCLES         ((`CONV_TIME_MAX_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// host margin over pin synchroniser latency
`define SYNC_MARGIN_CYCLES  8

// host serial clock made by a divider
`define SCK_PERIOD_NS       160
`define SCK_HALF_CYCLES     (`SCK_PERIOD_NS / (2 * `CLK_PERIOD_NS))

// select line setup before conversion start rises
`define SETUP_CYCLES        4

`endif

//--- hdl/sar_link_pkg.sv
package sar_link_pkg;

    typedef enum logic [1:0] {
        MODE_THREE_WIRE,
        MODE_FOUR_WIRE,
        MODE_CHAIN
    } link_mode_e;

    typedef enum logic {
        DEV_ACQUIRE,
        DEV_CONVERT
    } dev_state_e;

    typedef enum logic [2:0] {
        HOST_IDLE,
        HOST_ARM,
        HOST_CONVERT,
        HOST_SELECT,
        HOST_SCK_HIGH,
        HOST_SCK_LOW,
        HOST_DONE
    } host_state_e;

endpackage : sar_link_pkg

//--- hdl/sar_link_if.sv
interface sar_link_if;
    // driven by the host
    logic conversion_start;
    logic sck;
    logic select_or_chain_input;
    // three-state serial output of the converter
    logic result_serial_output;
    logic result_serial_oe;
    // line level seen by the host; undriven line modelled as a low keeper
    logic result_line;

    assign result_line = result_serial_oe ? result_serial_output : 1'b0;

    modport converter (
        input  conversion_start,
        input  sck,
        input  select_or_chain_input,
        output result_serial_output,
        output result_serial_oe
    );

    modport host (
        output conversion_start,
        output sck,
        output select_or_chain_input,
        input  result_line
    );
endinterface : sar_link_if

//--- hdl/sar_converter_end.sv
// Overview of operation
// R1 - conversion start rise latches select line mode
// R2 - host waits longest conversion before readback
// R3 - three-wire: start converts, select mode, release output
// R4 - after conversion, acquire and power down
// R5 - three-wire: start low shows first result bit
// R6 - each sck fall shifts next bit, msb first
// R7 - bits stay valid across both sck edges
// R8 - three-wire: release at 18th fall or start rise
// R9 - four-wire: host holds start high throughout
// R10 - select and start low drive output low
// R11 - host raises select before shortest conversion ends
// R12 - four-wire: select low shows first result bit
// R13 - four-wire: release at 18th fall or select rise
// R14 - start rise, sck and input low: chain
// R15 - chain: host holds start high through readback
// R16 - chain: msb shown when conversion completes
// R17 - chain: serial input shifts in each fall
// R18 - host gives 18 times N sck cycles
// R19 - host keeps sck still during conversion
`include "sar_link_defines.svh"

module sar_converter_end
    import sar_link_pkg::*;
#(
    parameter int RESULT_BITS = `RESULT_BITS,
    parameter int CONV_CYCLES = `CONV_CYCLES
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset,
    // link pins
    sar_link_if.converter               link,
    // user side: value to convert and status
    input  wire logic [RESULT_BITS-1:0] sample_data,
    output logic                        converting,
    output logic                        powered_down,
    output logic                        chain_mode
);

    localparam int CNT_W = $clog2(CONV_CYCLES + 1);
    localparam int BIT_W = $clog2(RESULT_BITS + 1);
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
    localparam logic [BIT_W-1:0] BIT_LAST  = BIT_W'(RESULT_BITS - 1);

    // pin synchronisers: bit 0 start, bit 1 sck, bit 2 select/chain input
    logic [2:0] meta_reg;
    logic [2:0] pin_reg;
    logic [2:0] prev_reg;
    logic [2:0] meta_next;
    logic [2:0] pin_next;
    logic [2:0] prev_next;

    always_comb begin
        meta_next = {link.select_or_chain_input, link.sck, link.conversion_start};
        pin_next  = meta_reg;
        prev_next = pin_reg;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_reg <= 3'h0;
            pin_reg  <= 3'h0;
            prev_reg <= 3'h0;
        end else begin
            meta_reg <= meta_next;
            pin_reg  <= pin_next;
            prev_reg <= prev_next;
        end
    end

    logic start_q;
    logic sel_q;
    logic start_rise;
    logic sck_fall;

    assign start_q    = pin_reg[0];
    assign sel_q      = pin_reg[2];
    assign start_rise = pin_reg[0] & ~prev_reg[0];
    assign sck_fall   = ~pin_reg[1] & prev_reg[1];

    // conversion and readout state
    dev_state_e             state_reg;
    dev_state_e             state_next;
    logic                   chain_reg;
    logic                   chain_next;
    logic                   ready_reg;
    logic                   ready_next;
    logic                   reading_reg;
    logic                   reading_next;
    logic [RESULT_BITS-1:0] shift_reg;
    logic [RESULT_BITS-1:0] shift_next;
    logic [BIT_W-1:0]       bit_cnt_reg;
    logic [BIT_W-1:0]       bit_cnt_next;
    logic [CNT_W-1:0]       conv_cnt_reg;
    logic [CNT_W-1:0]       conv_cnt_next;
    logic                   read_open;

    // select-mode window: start low (three-wire) or select low (four-wire)
    assign read_open = ~start_q | ~sel_q;

    always_comb begin
        state_next    = state_reg;
        chain_next    = chain_reg;
        ready_next    = ready_reg;
        reading_next  = reading_reg;
        shift_next    = shift_reg;
        bit_cnt_next  = bit_cnt_reg;
        conv_cnt_next = conv_cnt_reg;
        if (start_rise) begin
            // a start edge always restarts, even mid readout
            state_next    = DEV_CONVERT; // R3
            chain_next    = ~sel_q; // R1 R14
            shift_next    = sample_data;
            ready_next    = 1'b0;
            reading_next  = 1'b0; // R8
            bit_cnt_next  = '0;
            conv_cnt_next = '0;
        end else begin
            unique case (state_reg)
                DEV_CONVERT: begin
                    if (conv_cnt_reg == CONV_LAST) begin
                        state_next = DEV_ACQUIRE; // R4
                        ready_next = 1'b1;
                    end else begin
                        conv_cnt_next = conv_cnt_reg + 1'b1;
                    end
                end
                DEV_ACQUIRE: begin
                    if (ready_reg && chain_reg) begin
                        if (!start_q) begin
                            ready_next = 1'b0;
                        end else if (sck_fall) begin
                            shift_next = {shift_reg[RESULT_BITS-2:0], sel_q}; // R17
                        end
                    end else if (ready_reg) begin
                        if (reading_reg) begin
                            if (!read_open) begin
                                // one read per conversion; closing the window ends it
                                reading_next = 1'b0; // R8 R13
                                ready_next   = 1'b0;
                            end else if (sck_fall) begin
                                shift_next   = {shift_reg[RESULT_BITS-2:0], 1'b0}; // R6
                                bit_cnt_next = bit_cnt_reg + 1'b1;
                                if (bit_cnt_reg == BIT_LAST) begin
                                    reading_next = 1'b0; // R8 R13
                                    ready_next   = 1'b0;
                                end
                            end
                        end else if (read_open) begin
                            reading_next = 1'b1; // R5 R12
                            bit_cnt_next = '0;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg    <= DEV_ACQUIRE;
            chain_reg    <= 1'b0;
            ready_reg    <= 1'b0;
            reading_reg  <= 1'b0;
            shift_reg    <= '0;
            bit_cnt_reg  <= '0;
            conv_cnt_reg <= '0;
        end else begin
            state_reg    <= state_next;
            chain_reg    <= chain_next;
            ready_reg    <= ready_next;
            reading_reg  <= reading_next;
            shift_reg    <= shift_next;
            bit_cnt_reg  <= bit_cnt_next;
            conv_cnt_reg <= conv_cnt_next;
        end
    end

    // output pin and status, registered from next values
    logic out_reg;
    logic out_next;
    logic oe_reg;
    logic oe_next;
    logic converting_reg;
    logic powered_down_reg;
    logic chain_mode_reg;

    always_comb begin
        out_next = 1'b0;
        oe_next  = 1'b0;
        if (state_next == DEV_ACQUIRE && ready_next && chain_next) begin
            out_next = shift_next[RESULT_BITS-1]; // R16
            oe_next  = 1'b1;
        end else if (reading_next) begin
            // bit held until the next fall, so both sck edges see it
            out_next = shift_next[RESULT_BITS-1]; // R7
            oe_next  = 1'b1;
        end else if (!start_q && !sel_q && !start_rise) begin
            oe_next = 1'b1; // R10
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            out_reg          <= 1'b0;
            oe_reg           <= 1'b0;
            converting_reg   <= 1'b0;
            powered_down_reg <= 1'b1;
            chain_mode_reg   <= 1'b0;
        end else begin
            out_reg          <= out_next;
            oe_reg           <= oe_next;
            converting_reg   <= (state_next == DEV_CONVERT);
            powered_down_reg <= (state_next == DEV_ACQUIRE); // R4
            chain_mode_reg   <= chain_next;
        end
    end

    assign link.result_serial_output = out_reg;
    assign link.result_serial_oe     = oe_reg;
    assign converting                = converting_reg;
    assign powered_down              = powered_down_reg;
    assign chain_mode                = chain_mode_reg;

endmodule : sar_converter_end

//--- verification/sar_link_properties.sv
module sar_link_properties #(
    parameter int CONV_CYCLES = 20
) (
    // clock and reset
    input logic clk,
    input logic reset,
    // link pins
    input logic conversion_start,
    input logic sck,
    input logic select_or_chain_input,
    input logic result_serial_output,
    input logic result_serial_oe,
    input logic result_line
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       go_q_reg, go_q_next, sck_q_reg, sck_q_next, chain_reg, chain_next;
    logic [9:0] age_reg, age_next;
    logic [4:0] falls_reg, falls_next;
    logic [5:0] since_reg, since_next;

    // age and since counters saturate so a long idle never wraps into a false match; the fall counter does not saturate
    always_comb begin
        go_q_next  = conversion_start;
        sck_q_next = sck;
        chain_next = chain_reg;
        age_next   = (age_reg == 10'h3FF) ? age_reg : age_reg + 10'h001;
        falls_next = falls_reg;
        since_next = (since_reg == 6'h3F) ? since_reg : since_reg + 6'h01;
        if (conversion_start && !go_q_reg) begin
            chain_next = !select_or_chain_input;
            age_next   = 10'h000;
        end
        if (sck_q_reg && !sck) begin
            falls_next = falls_reg + 5'h01;
            since_next = 6'h00;
        end
        if (!result_serial_oe) begin
            falls_next = 5'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            go_q_reg  <= 1'b0;
            sck_q_reg <= 1'b0;
            chain_reg <= 1'b0;
            age_reg   <= 10'h000;
            falls_reg <= 5'h00;
            since_reg <= 6'h3F;
        end else begin
            go_q_reg  <= go_q_next;
            sck_q_reg <= sck_q_next;
            chain_reg <= chain_next;
            age_reg   <= age_next;
            falls_reg <= falls_next;
            since_reg <= since_next;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_go_rise;
        $rose(conversion_start);
    endsequence
    sequence s_line_quiet;
        !result_serial_oe [*8];
    endsequence
    sequence s_cs_fall;
        $fell(sck) && result_serial_oe && !chain_reg;
    endsequence

    property p_release_on_start;
        s_go_rise |-> ##5 s_line_quiet;
    endproperty
    a_release_on_start: assert property (p_release_on_start) else $error("output driven in conversion");
    property p_chain_msb;
        chain_reg && conversion_start && age_reg == CONV_CYCLES + 6 |-> result_serial_oe && !sck;
    endproperty
    a_chain_msb: assert property (p_chain_msb) else $error("chain msb not shown");
    property p_shift_on_fall;
        $changed(result_serial_output) && result_serial_oe && $past(result_serial_oe) && falls_reg != 5'h00
            && (conversion_start || !chain_reg) |-> since_reg <= 6'h05;
    endproperty
    a_shift_on_fall: assert property (p_shift_on_fall) else $error("bit changed away from sck fall");
    property p_hold_high;
        sck && $past(sck) && result_serial_oe && $past(result_serial_oe) |-> $stable(result_line);
    endproperty
    a_hold_high: assert property (p_hold_high) else $error("bit moved while sck high");
    property p_release_18;
        s_cs_fall and falls_reg == 5'h11 |-> ##[1:6] !result_serial_oe;
    endproperty
    a_release_18: assert property (p_release_18) else $error("no release after last fall");
    property p_no_early;
        s_cs_fall and falls_reg < 5'h10 |-> result_serial_oe [*6];
    endproperty
    a_no_early: assert property (p_no_early) else $error("early release");
    property p_drive_low;
        (!select_or_chain_input && !conversion_start) [*6] |-> result_serial_oe && !result_serial_output;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("line not driven low");
    property p_read_waits;
        $rose(sck) |-> age_reg >= CONV_CYCLES;
    endproperty
    a_read_waits: assert property (p_read_waits) else $error("readback before conversion end");
    property p_sck_still;
        s_go_rise |-> !sck [*8];
    endproperty
    a_sck_still: assert property (p_sck_still) else $error("sck moving in conversion");
    property p_chain_entry;
        $rose(conversion_start) && !select_or_chain_input |-> !sck;
    endproperty
    a_chain_entry: assert property (p_chain_entry) else $error("chain entry with sck high");
endmodule : sar_link_properties

//--- verification/sar_adc_serial_readout_tb_top.sv
module sar_adc_serial_readout_tb_top
    import sar_link_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // short conversion keeps the run brief
    localparam int CONV_CYC = 20;

    logic        clk, reset, start, result_valid, busy, converting, powered_down, chain_mode;
    link_mode_e  mode;
    logic [2:0]  chain_len_m1, result_index;
    logic [17:0] sample_data, result_word;
    int          num_errors, check_count;

    sar_link_if link_bus ();

    sar_converter_end #(.CONV_CYCLES(CONV_CYC)) u_sar_converter_end (
        .clk(clk), .reset(reset), .link(link_bus), .sample_data(sample_data),
        .converting(converting), .powered_down(powered_down), .chain_mode(chain_mode));

    sar_host_end #(.WAIT_CYCLES(CONV_CYC + 8)) u_sar_host_end (
        .clk(clk), .reset(reset), .link(link_bus), .start(start), .mode(mode), .chain_len_m1(chain_len_m1),
        .result_word(result_word), .result_valid(result_valid), .result_index(result_index), .busy(busy));

    sar_link_properties #(.CONV_CYCLES(CONV_CYC)) u_sar_link_properties (
        .clk(clk), .reset(reset), .conversion_start(link_bus.conversion_start), .sck(link_bus.sck),
        .select_or_chain_input(link_bus.select_or_chain_input), .result_serial_output(link_bus.result_serial_output),
        .result_serial_oe(link_bus.result_serial_oe), .result_line(link_bus.result_line));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic give_verdict;
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic check_word(input logic [17:0] got, input logic [17:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp, input string what);
        check_word({17'h00000, got}, {17'h00000, exp}, what);
    endtask : check_bit

    task automatic time_out(input string what);
        num_errors++;
        $display("MISMATCH %0t %s timed out", $time, what);
        give_verdict();
    endtask : time_out

    task automatic launch(input link_mode_e m, input logic [17:0] pat);
        @(posedge clk);
        sample_data <= pat;
        mode <= m;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask : launch

    task automatic wait_word(output logic [17:0] word, output logic [2:0] idx);
        int n;
        for (n = 0; n < 2000 && result_valid !== 1'b1; n++) @(posedge clk);
        if (n == 2000) time_out("result word");
        word = result_word;
        idx = result_index;
    endtask : wait_word

    // a stray valid while draining means a refused start slipped through
    task automatic wait_idle(output int extra);
        int n;
        extra = 0;
        for (n = 0; n < 2000 && busy !== 1'b0; n++) begin
            @(posedge clk);
            if (result_valid === 1'b1) extra++;
        end
        if (n == 2000) time_out("idle");
    endtask : wait_idle

    task automatic run_transfer(input link_mode_e m, input logic [17:0] pat, input logic exp_chain);
        logic [17:0] word;
        logic [2:0]  idx;
        int          n;
        launch(m, pat);
        for (n = 0; n < 200 && converting !== 1'b1; n++) @(posedge clk);
        if (n == 200) time_out("conversion");
        for (n = 0; n < 200 && powered_down !== 1'b1; n++) @(posedge clk);
        if (n == 200) time_out("power down");
        check_bit(converting, 1'b0, "converting after done");
        check_bit(chain_mode, exp_chain, "mode latch");
        wait_word(word, idx);
        check_word(word, pat, "result word");
        check_bit(idx === 3'h0, 1'b1, "word index");
        wait_idle(n);
        check_word(n[17:0], 18'h00000, "extra words");
    endtask : run_transfer

    task automatic t_three_wire;
        run_transfer(MODE_THREE_WIRE, 18'h2AAAA, 1'b0);
        run_transfer(MODE_THREE_WIRE, 18'h3FFFF, 1'b0);
    endtask : t_three_wire

    task automatic t_four_wire;
        run_transfer(MODE_FOUR_WIRE, 18'h15555, 1'b0);
        run_transfer(MODE_FOUR_WIRE, 18'h00001, 1'b0);
    endtask : t_four_wire

    task automatic t_chain;
        run_transfer(MODE_CHAIN, 18'h20000, 1'b1);
        run_transfer(MODE_CHAIN, 18'h1E0F3, 1'b1);
    endtask : t_chain

    // second start lands in the select phase, before the first sample is taken
    task automatic t_refused;
        logic [17:0] word;
        logic [2:0]  idx;
        int          extra;
        launch(MODE_THREE_WIRE, 18'h0F0F0);
        repeat (40) @(posedge clk);
        launch(MODE_CHAIN, 18'h30303);
        wait_word(word, idx);
        check_word(word, 18'h0F0F0, "refused start word");
        check_bit(chain_mode, 1'b0, "refused start mode");
        wait_idle(extra);
        check_word(extra[17:0], 18'h00000, "refused start words");
        repeat (60) @(posedge clk);
        check_bit(busy, 1'b0, "refused start busy");
    endtask : t_refused

    initial begin
        reset = 1'b1;
        start = 1'b0;
        mode = MODE_THREE_WIRE;
        chain_len_m1 = 3'h0;
        sample_data = 18'h00000;
        num_errors = 0;
        check_count = 0;
        repeat (16) @(posedge clk);
        check_bit(link_bus.result_serial_oe, 1'b0, "oe in reset");
        reset <= 1'b0;
        t_three_wire();
        t_four_wire();
        t_chain();
        t_refused();
        give_verdict();
    end
endmodule : sar_adc_serial_readout_tb_top
